// ===== verilog/epi_defines.svh
// Register offsets, field positions and reset values of the pin interrupt block
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH

// I/O offsets (mask group 2 printed; the rest coined)
`define EPI_OFS_CHG2_MASK 6'h05
`define EPI_OFS_CHG1_MASK 6'h04
`define EPI_OFS_CHG0_MASK 6'h03
`define EPI_OFS_FLAGS 6'h3A
`define EPI_OFS_ENABLES 6'h3B
`define EPI_OFS_CORE_CTRL 6'h35

// Flag / enable register bit positions
`define EPI_BIT_PIN_B 7
`define EPI_BIT_PIN_A 6
`define EPI_BIT_GRP0 5
`define EPI_BIT_GRP2 4
`define EPI_BIT_GRP1 3

// Sense control field positions in the core control register
`define EPI_SENSE_A_LSB 0
`define EPI_SENSE_B_LSB 2

// Widths of the change groups
`define EPI_GRP0_W 8
`define EPI_GRP1_W 3
`define EPI_GRP2_W 7

// Reset value of every register
`define EPI_RESET_BYTE 8'h00

// Readable bit masks
`define EPI_FLAGS_RMASK 8'hF8
`define EPI_CHG2_RMASK 8'h7F
`define EPI_CHG1_RMASK 8'h07

`endif

// ===== verilog/epi_pkg.sv
// Types shared by the pin interrupt block
package epi_pkg;

    // Sense selection for a dedicated interrupt pin
    typedef enum logic [1:0] {
        EPI_SENSE_LOW = 2'h0,
        EPI_SENSE_ANY = 2'h1,
        EPI_SENSE_FALL = 2'h2,
        EPI_SENSE_RISE = 2'h3
    } epi_sense_type;

endpackage : epi_pkg

// ===== verilog/epi_sync.sv
// Two-stage synchroniser with a previous-sample stage for edge detection
`timescale 1ns/1ps
module epi_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Raw pins
    input wire logic [WIDTH-1:0] i_pin,
    // Synchronised current and previous samples
    output logic [WIDTH-1:0] o_cur,
    output logic [WIDTH-1:0] o_prev
);

    logic [WIDTH-1:0] meta_q; // First stage, read only by the second
    logic [WIDTH-1:0] cur_q;
    logic [WIDTH-1:0] prev_q;

    // Pins shift through three stages; last two form the comparison pair
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            cur_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= i_pin;
            cur_q <= meta_q;
            prev_q <= cur_q;
        end
    end

    assign o_cur = cur_q;
    assign o_prev = prev_q;

endmodule : epi_sync

// ===== verilog/epi_flag.sv
// One sticky interrupt flag with hardware set and two clear paths
`timescale 1ns/1ps
module epi_flag (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Set and clear causes
    input wire logic i_set,
    input wire logic i_clr_sw,
    input wire logic i_clr_ack,
    input wire logic i_hold_zero,
    // Flag state
    output logic o_flag
);

    logic flag_q;
    logic flag_d;

    // Set wins over either clear; forced level mode holds zero
    always_comb begin
        flag_d = flag_q;
        if (i_clr_sw || i_clr_ack) begin
            flag_d = 1'b0;
        end
        if (i_set) begin
            flag_d = 1'b1;
        end
        if (i_hold_zero) begin
            flag_d = 1'b0;
        end
    end

    // Flag register
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign o_flag = flag_q;

endmodule : epi_flag

// ===== verilog/epi_top.sv
// Flags, enables and pin masks of the external pin interrupts
`timescale 1ns/1ps
`include "epi_defines.svh"
module epi_top
    import epi_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // I/O register port of the core
    input wire logic [5:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    // Core status global interrupt bit and vector entry
    input wire logic i_global_int_en,
    input wire logic [4:0] i_vector_ack,
    // External pins
    input wire logic i_ext_pin_a,
    input wire logic i_ext_pin_b,
    input wire logic [`EPI_GRP0_W-1:0] i_group0_pins,
    input wire logic [`EPI_GRP1_W-1:0] i_group1_pins,
    input wire logic [`EPI_GRP2_W-1:0] i_group2_pins,
    // Vector requests: [4]=pin B,[3]=pin A,[2]=grp0,[1]=grp2,[0]=grp1
    output logic [4:0] o_vector_req,
    // Level request lines for low-level sense
    output logic o_level_req_a,
    output logic o_level_req_b
);

    // Pin bus layout, low to high: pin A, pin B, group 0, group 1, group 2.
    // Every pin slice below is cut from this one packed bus.
    localparam int NPIN = 2 + `EPI_GRP0_W + `EPI_GRP1_W + `EPI_GRP2_W; // Count of synchronised pins

    // Reset release synchroniser
    // Assertion acts at once; release waits two edges, so no flop sees
    // reset lift close to a clock edge.
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_b;

    // Release reset through two flops, assert asynchronously
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_b = rst_sync_q;

    // Register state
    logic [7:0] enables_q; // Interrupt enable register
    logic [7:0] enables_d;
    logic [3:0] sense_q; // Sense bits of core control register
    logic [3:0] sense_d;
    // Per-pin masks, one bit for each pin of a change group
    logic [`EPI_GRP0_W-1:0] chg0_mask_q; // Group-0 mask
    logic [`EPI_GRP0_W-1:0] chg0_mask_d;
    logic [`EPI_GRP1_W-1:0] chg1_mask_q;
    logic [`EPI_GRP1_W-1:0] chg1_mask_d;
    logic [`EPI_GRP2_W-1:0] chg2_mask_q;
    logic [`EPI_GRP2_W-1:0] chg2_mask_d;
    logic [7:0] core_hi_q; // Unrelated upper bits of core control, kept as storage
    logic [7:0] core_hi_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // Address match helper used by both write and read decode
    // Exact compare, so no offset is aliased onto another
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // Write decode for the plain storage registers
    // The flag register is not stored here: a write to it only clears bits,
    // which the flag bank handles below.
    always_comb begin
        enables_d = enables_q;
        sense_d = sense_q;
        core_hi_d = core_hi_q;
        chg0_mask_d = chg0_mask_q;
        chg1_mask_d = chg1_mask_q;
        chg2_mask_d = chg2_mask_q;
        if (i_io_wr) begin
            if (hit(i_io_addr, `EPI_OFS_ENABLES)) begin
                // Low three enable bits are reserved
                enables_d = i_io_wdata & `EPI_FLAGS_RMASK;
            end
            // Sense fields of both pins, upper bits kept as storage
            if (hit(i_io_addr, `EPI_OFS_CORE_CTRL)) begin
                sense_d = i_io_wdata[3:0];
                core_hi_d = {i_io_wdata[7:4], 4'h0};
            end
            // Group-0 mask uses all eight bits
            if (hit(i_io_addr, `EPI_OFS_CHG0_MASK)) begin
                chg0_mask_d = i_io_wdata;
            end
            if (hit(i_io_addr, `EPI_OFS_CHG1_MASK)) begin
                chg1_mask_d = i_io_wdata[`EPI_GRP1_W-1:0];
            end
            if (hit(i_io_addr, `EPI_OFS_CHG2_MASK)) begin
                chg2_mask_d = i_io_wdata[`EPI_GRP2_W-1:0];
            end
        end
    end

    // Storage registers, all reset to zero
    // Reset is the released copy, like every flop of the block outside the reset synchroniser
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            enables_q <= `EPI_RESET_BYTE;
            sense_q <= 4'h0;
            core_hi_q <= `EPI_RESET_BYTE;
            chg0_mask_q <= '0;
            chg1_mask_q <= '0;
            chg2_mask_q <= '0;
        end else begin
            enables_q <= enables_d;
            sense_q <= sense_d;
            core_hi_q <= core_hi_d;
            chg0_mask_q <= chg0_mask_d;
            chg1_mask_q <= chg1_mask_d;
            chg2_mask_q <= chg2_mask_d;
        end
    end

    // Synchronise every pin; the extra stage gives the previous sample
    // Three flops cost one cycle over the minimum but keep the previous
    // sample on the same clean timing as the current one.
    logic [NPIN-1:0] pin_cur;
    logic [NPIN-1:0] pin_prev;
    epi_sync #(
        .WIDTH(NPIN)
    ) u_sync (
        // Runs on the released reset so no pin history predates it
        .i_clk_sys(i_clk_sys),
        .i_rst_b(rst_b),
        .i_pin({i_group2_pins, i_group1_pins, i_group0_pins, i_ext_pin_b, i_ext_pin_a}),
        .o_cur(pin_cur),
        .o_prev(pin_prev)
    );

    // Edge detection per dedicated pin
    // A change is any difference between current and previous sample; after
    // reset both stages hold zero, and the reset enables keep that quiet.
    logic [1:0] ext_event;
    logic [1:0] ext_level;
    logic [NPIN-1:0] pin_chg;
    assign pin_chg = pin_cur ^ pin_prev;

    // Decode one sense selection into an event
    // Low level gives no event here; its request is the level line below
    function automatic logic sense_event(input epi_sense_type sel, input logic cur, input logic prev);
        unique case (sel)
            EPI_SENSE_LOW: sense_event = 1'b0;
            EPI_SENSE_ANY: sense_event = cur ^ prev;
            EPI_SENSE_FALL: sense_event = prev & ~cur;
            EPI_SENSE_RISE: sense_event = cur & ~prev;
        endcase
    endfunction : sense_event

    always_comb begin
        ext_event[0] = sense_event(epi_sense_type'(sense_q[`EPI_SENSE_A_LSB +: 2]), pin_cur[0], pin_prev[0]);
        ext_event[1] = sense_event(epi_sense_type'(sense_q[`EPI_SENSE_B_LSB +: 2]), pin_cur[1], pin_prev[1]);
        ext_level[0] = (sense_q[`EPI_SENSE_A_LSB +: 2] == EPI_SENSE_LOW);
        ext_level[1] = (sense_q[`EPI_SENSE_B_LSB +: 2] == EPI_SENSE_LOW);
    end

    // Group change events; mask selects contributing pins.
    // Gating the set by the group enable keeps a disabled group quiet.
    // Limitation: a change while its group is disabled is dropped, not held,
    // so software reads the pins itself after enabling a group.
    logic grp0_event;
    logic grp1_event;
    logic grp2_event;
    assign grp0_event = enables_q[`EPI_BIT_GRP0] & |(pin_chg[2 +: `EPI_GRP0_W] & chg0_mask_q);
    assign grp1_event = enables_q[`EPI_BIT_GRP1] & |(pin_chg[2 + `EPI_GRP0_W +: `EPI_GRP1_W] & chg1_mask_q);
    assign grp2_event = enables_q[`EPI_BIT_GRP2]
        & |(pin_chg[2 + `EPI_GRP0_W + `EPI_GRP1_W +: `EPI_GRP2_W] & chg2_mask_q);

    // Flag bank in request order: B, A, grp0, grp2, grp1
    // Each flag has a hardware set, a software write-one clear and the
    // vector entry clear. Set wins so that an event arriving while the
    // routine is entered is never lost.
    logic [4:0] flag_set;
    logic [4:0] flag_clr_sw;
    logic [4:0] flag_hold;
    logic [4:0] flag;
    logic flags_wr;
    assign flags_wr = i_io_wr & hit(i_io_addr, `EPI_OFS_FLAGS);
    assign flag_set = {ext_event[1], ext_event[0], grp0_event, grp2_event, grp1_event};
    assign flag_clr_sw = flags_wr ? i_io_wdata[7:3] : 5'h00;
    assign flag_hold = {ext_level[1], ext_level[0], 3'h0};

    // One flag cell per request source
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_flag
            epi_flag u_flag (
                .i_clk_sys(i_clk_sys),
                .i_rst_b(rst_b),
                .i_set(flag_set[g]),
                .i_clr_sw(flag_clr_sw[g]),
                .i_clr_ack(i_vector_ack[g]),
                .i_hold_zero(flag_hold[g]),
                .o_flag(flag[g])
            );
        end
    endgenerate

    // Combinational so the core sees a request in the cycle the flag sets
    // flag, enable and global bit
    assign o_vector_req = flag & enables_q[7:3] & {5{i_global_int_en}};

    // Low level requests bypass the flags and stay while the pin is low
    // Trade-off: with no flag there is no latch, so a low level removed
    // before the core responds leaves no trace.
    assign o_level_req_a = ext_level[0] & ~pin_cur[0] & enables_q[`EPI_BIT_PIN_A] & i_global_int_en;
    assign o_level_req_b = ext_level[1] & ~pin_cur[1] & enables_q[`EPI_BIT_PIN_B] & i_global_int_en;

    // Read mux, registered so data appears the cycle after the strobe
    // Unmapped offsets return zero; a read never disturbs a flag
    always_comb begin
        rdata_d = rdata_q;
        if (i_io_rd) begin
            rdata_d = 8'h00;
            if (hit(i_io_addr, `EPI_OFS_FLAGS)) begin
                rdata_d = {flag, 3'h0};
            end
            // Enables read back with the reserved bits at zero
            if (hit(i_io_addr, `EPI_OFS_ENABLES)) begin
                rdata_d = enables_q;
            end
            // Core control reads back whole
            if (hit(i_io_addr, `EPI_OFS_CORE_CTRL)) begin
                rdata_d = core_hi_q | {4'h0, sense_q};
            end
            if (hit(i_io_addr, `EPI_OFS_CHG0_MASK)) begin
                rdata_d = chg0_mask_q;
            end
            if (hit(i_io_addr, `EPI_OFS_CHG1_MASK)) begin
                rdata_d = {5'h00, chg1_mask_q};
            end
            if (hit(i_io_addr, `EPI_OFS_CHG2_MASK)) begin
                rdata_d = {1'b0, chg2_mask_q};
            end
        end
    end

    // Read data register
    // Holds the last read value until the next read strobe
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= `EPI_RESET_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_io_rdata = rdata_q;

endmodule : epi_top

// ===== sim/epi_top_assertions.sv
// Port-level checks on the pin interrupt block
`timescale 1ns/1ps
module epi_top_assertions (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Register port
    input wire logic [5:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    input wire logic [7:0] o_io_rdata,
    // Core side and pins
    input wire logic i_global_int_en,
    input wire logic [4:0] i_vector_ack,
    input wire logic i_ext_pin_a,
    input wire logic i_ext_pin_b,
    input wire logic [4:0] o_vector_req,
    input wire logic o_level_req_a
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    chk_req_needs_global: assert property (
        !i_global_int_en |-> o_vector_req == 5'h00) else $error("request without global bit");
    chk_flags_reserved: assert property (
        $past(i_io_rd) && $past(i_io_addr) == 6'h3A |-> o_io_rdata[2:0] == 3'h0)
        else $error("flag reserved bits not zero");
    chk_mask2_top: assert property (
        $past(i_io_rd) && $past(i_io_addr) == 6'h05 |-> !o_io_rdata[7]) else $error("mask2 bit 7 set");
    chk_mask1_high: assert property (
        $past(i_io_rd) && $past(i_io_addr) == 6'h04 |-> o_io_rdata[7:3] == 5'h00)
        else $error("mask1 upper bits set");
    chk_unmapped_zero: assert property (
        $past(i_io_rd) && !($past(i_io_addr) inside {6'h03, 6'h04, 6'h05, 6'h35, 6'h3A, 6'h3B})
        |-> o_io_rdata == 8'h00) else $error("unmapped read not zero");
    chk_rdata_holds: assert property (
        !$past(i_io_rd) |-> $stable(o_io_rdata)) else $error("read data moved without read");
    // Pin B quiet for five samples means no fresh event can refill the flag
    chk_ack_clears: assert property (
        i_vector_ack[4] && $past(i_ext_pin_b) == i_ext_pin_b && $past(i_ext_pin_b, 2) == i_ext_pin_b
        && $past(i_ext_pin_b, 3) == i_ext_pin_b && $past(i_ext_pin_b, 4) == i_ext_pin_b
        |=> !o_vector_req[4]) else $error("vector entry left flag set");
    chk_write_clears: assert property (
        i_io_wr && i_io_addr == 6'h3A && i_io_wdata[7] && $stable(i_ext_pin_b)
        && $past(i_ext_pin_b, 2) == i_ext_pin_b && $past(i_ext_pin_b, 3) == i_ext_pin_b
        ##1 $stable(i_ext_pin_b) |-> !o_vector_req[4]) else $error("write one left flag set");
    chk_level_high_pin: assert property (
        i_ext_pin_a && $past(i_ext_pin_a) && $past(i_ext_pin_a, 2) && $past(i_ext_pin_a, 3)
        |-> !o_level_req_a) else $error("level request with pin high");
endmodule : epi_top_assertions

bind epi_top epi_top_assertions u_chk (.i_clk_sys, .i_rst_b, .i_io_addr, .i_io_wr, .i_io_rd,
    .i_io_wdata, .o_io_rdata, .i_global_int_en, .i_vector_ack, .i_ext_pin_a, .i_ext_pin_b,
    .o_vector_req, .o_level_req_a);

// ===== sim/epi_core_model.sv
// Behavioural core that enters interrupt routines on request
`timescale 1ns/1ps
module epi_core_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Requests and answer control
    input wire logic [4:0] i_req,
    input wire logic i_take,
    input wire logic [3:0] i_wait,
    // Vector entry pulses
    output logic [4:0] o_ack
);
    logic [3:0] cnt_q; // Cycles waited on a pending request

    // Drives on the falling edge like the rest of the bench; i_wait makes it slow
    // vector entry pulse
    always @(negedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ack <= 5'h00;
            cnt_q <= 4'h0;
        end else if (o_ack != 5'h00) begin
            // One-cycle pulse, then the flag has gone
            o_ack <= 5'h00;
            cnt_q <= 4'h0;
        end else if (i_take && i_req != 5'h00) begin
            if (cnt_q >= i_wait) begin
                o_ack <= i_req & ~(i_req - 5'h01);
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end else begin
            cnt_q <= 4'h0;
        end
    end
endmodule : epi_core_model

// ===== sim/epi_top_tb.sv
// Self-checking bench for the pin interrupt flags and masks
`timescale 1ns/1ps
module epi_top_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [5:0] i_io_addr = 6'h00;
    logic i_io_wr = 1'b0;
    logic i_io_rd = 1'b0;
    logic [7:0] i_io_wdata = 8'h00;
    logic [7:0] o_io_rdata;
    logic i_global_int_en = 1'b0;
    logic [4:0] i_vector_ack;
    logic i_ext_pin_a = 1'b0;
    logic i_ext_pin_b = 1'b0;
    logic [7:0] i_group0_pins = 8'h00;
    logic [2:0] i_group1_pins = 3'h0;
    logic [6:0] i_group2_pins = 7'h00;
    logic [4:0] o_vector_req;
    logic o_level_req_a;
    logic o_level_req_b;
    logic take = 1'b0; // Core enters routines only when set
    logic [3:0] wt = 4'h5; // Core answer delay
    logic [7:0] d;
    int n_fail = 0;
    int n_tests = 0;
    int fb[3] = '{5, 3, 4}; // Flag bit of each change group
    logic [5:0] ma[3] = '{6'h03, 6'h04, 6'h05}; // Mask offset of each group
    logic [5:0] ra[7] = '{6'h03, 6'h04, 6'h05, 6'h35, 6'h3A, 6'h3B, 6'h10};

    // 200 MHz system clock
    always #2.5 i_clk_sys = ~i_clk_sys;

    epi_top dut (.i_clk_sys, .i_rst_b, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata,
        .i_global_int_en, .i_vector_ack, .i_ext_pin_a, .i_ext_pin_b, .i_group0_pins, .i_group1_pins,
        .i_group2_pins, .o_vector_req, .o_level_req_a, .o_level_req_b);
    epi_core_model core (.i_clk_sys, .i_rst_b, .i_req(o_vector_req), .i_take(take), .i_wait(wt),
        .o_ack(i_vector_ack));

    task automatic end_of_test;
        $display("Counts: %0d compared, %0d failed", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Strobes rise on one falling edge and drop on the next: one cycle each
    task automatic wr8(input logic [5:0] a, input logic [7:0] v);
        @(negedge i_clk_sys);
        i_io_addr = a;
        i_io_wdata = v;
        i_io_wr = 1'b1;
        @(negedge i_clk_sys);
        i_io_wr = 1'b0;
    endtask : wr8

    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        @(negedge i_clk_sys);
        i_io_addr = a;
        i_io_rd = 1'b1;
        @(negedge i_clk_sys);
        i_io_rd = 1'b0;
        chk(o_io_rdata, exp);
    endtask : rchk

    // A pin change needs three edges to reach its flag; six leaves margin
    // levels held far over one clock
    task automatic pin(input int p, input logic v);
        if (p == 0) i_ext_pin_a = v;
        else i_ext_pin_b = v;
        repeat (6) @(negedge i_clk_sys);
    endtask : pin

    task automatic grp(input int g, input int b);
        case (g)
            0: i_group0_pins[b] = ~i_group0_pins[b];
            1: i_group1_pins[b] = ~i_group1_pins[b];
            default: i_group2_pins[b] = ~i_group2_pins[b];
        endcase
        repeat (6) @(negedge i_clk_sys);
    endtask : grp

    // Watchdog well beyond the roughly 400 cycles the tests need
    initial begin
        repeat (6000) @(posedge i_clk_sys);
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (6) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        foreach (ra[i]) rchk(ra[i], 8'h00);
        $display("test reset values done");
        for (int g = 0; g < 3; g++) wr8(ma[g], 8'hFF);
        rchk(6'h05, 8'h7F);
        rchk(6'h04, 8'h07);
        rchk(6'h03, 8'hFF);
        rchk(6'h10, 8'h00);
        wr8(6'h3B, 8'hFF);
        rchk(6'h3B, 8'hF8);
        wr8(6'h35, 8'hA9);
        rchk(6'h35, 8'hA9);
        $display("test mask access done");
        // Every sense code on both dedicated pins, rising then falling
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                wr8(6'h35, 8'(s << (2 * p)));
                wr8(6'h3A, 8'hF8);
                pin(p, 1'b1);
                rchk(6'h3A, (s == 1 || s == 3) ? 8'(1 << (6 + p)) : 8'h00);
                wr8(6'h3A, 8'h07);
                rchk(6'h3A, (s == 1 || s == 3) ? 8'(1 << (6 + p)) : 8'h00);
                wr8(6'h3A, 8'hF8);
                pin(p, 1'b0);
                rchk(6'h3A, (s == 1 || s == 2) ? 8'(1 << (6 + p)) : 8'h00);
            end
        end
        $display("test sense modes done");
        wr8(6'h3B, 8'h38);
        wr8(6'h3A, 8'hF8);
        for (int g = 0; g < 3; g++) begin
            wr8(ma[g], 8'h01);
            grp(g, 1);
            rchk(6'h3A, 8'h00);
            grp(g, 0);
            rchk(6'h3A, 8'(1 << fb[g]));
            wr8(6'h3A, 8'hF8);
        end
        wr8(6'h3B, 8'h28);
        grp(2, 0);
        rchk(6'h3A, 8'h00);
        wr8(6'h3B, 8'h30);
        grp(1, 0);
        rchk(6'h3A, 8'h00);
        $display("test change groups done");
        wr8(6'h3B, 8'hF8);
        wr8(6'h35, 8'h0C);
        pin(1, 1'b1);
        chk({3'h0, o_vector_req}, 8'h00);
        i_global_int_en = 1'b1;
        @(negedge i_clk_sys);
        chk({3'h0, o_vector_req}, 8'h10);
        chk({7'h00, o_level_req_a}, 8'h01);
        take = 1'b1;
        repeat (12) @(negedge i_clk_sys);
        rchk(6'h3A, 8'h00);
        // Core held off: a fresh rise must raise the request again
        take = 1'b0;
        pin(1, 1'b0);
        pin(1, 1'b1);
        chk({3'h0, o_vector_req}, 8'h10);
        wr8(6'h3B, 8'h78);
        chk({3'h0, o_vector_req}, 8'h00);
        wr8(6'h3B, 8'hF8);
        wt = 4'h0;
        take = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        chk({3'h0, o_vector_req}, 8'h00);
        take = 1'b0;
        pin(0, 1'b1);
        chk({7'h00, o_level_req_a}, 8'h00);
        // Any-change sets pin B's flag; low-level sense must then wipe it
        wr8(6'h35, 8'h04);
        pin(1, 1'b0);
        rchk(6'h3A, 8'h80);
        wr8(6'h35, 8'h00);
        rchk(6'h3A, 8'h00);
        chk({7'h00, o_level_req_b}, 8'h01);
        $display("test vector entry done");
        end_of_test();
    end
endmodule : epi_top_tb
